// ==== dtu_pkg.sv ====
package dtu_pkg;
	// ==========================================
	// Clock and line rates
	// ==========================================
	localparam int unsigned CLK_HZ        = 125000000;  // System clock rate
	localparam int unsigned BOOT_BAUD     = 115200;     // Boot log line rate
	localparam int unsigned LOG_BAUD      = 921600;     // Default logging line rate
	localparam int unsigned BOOT_DIV      = CLK_HZ / BOOT_BAUD;  // Cycles per boot bit
	localparam int unsigned LOG_DIV       = CLK_HZ / LOG_BAUD;   // Cycles per log bit
	localparam int unsigned DIV_W         = 16;         // Bit timer width
	localparam int unsigned FRAME_BITS    = 10;         // Start, eight data, stop
	localparam int unsigned DATA_BITS     = 8;          // Data bits per frame
	localparam int unsigned FIFO_DEPTH    = 32;         // Words in each transmit FIFO
	localparam logic [1:0]  BOOT_FC_ON    = 2'h1;       // Boot config value enabling flow control

	// ==========================================
	// Trace modes
	// ==========================================
	typedef enum logic [1:0] {
		DTU_MODE_CUSTOMER = 2'h0,  // Port off after boot log
		DTU_MODE_LOG      = 2'h1,  // Logging
		DTU_MODE_ALT_LOG  = 2'h2,  // Alternate logging
		DTU_MODE_BOOT     = 2'h3   // Firmware upgrade
	} dtu_mode_e;

	// Configuration applied after the boot log
	typedef struct packed {
		dtu_mode_e   mode;         // Trace mode setting
		logic        log_fc_off;   // Logging mode flow control override off
		logic        log_baud_sel; // Logging mode uses boot rate when set
		logic [1:0]  boot_cfg;     // Boot config setting
	} dtu_cfg_s;

	// Byte stream carrier
	typedef struct packed {
		logic       valid;  // Byte present
		logic [7:0] data;   // Byte value
	} dtu_byte_s;
endpackage

// ==== dtu_fifo.sv ====
`timescale 1ns/10ps
module dtu_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             i_clk,
	input  wire logic             i_arst_n,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("Depth must be a power of two");
	end
	// ==========================================
	// Storage and pointers
	// ==========================================
	logic [WIDTH-1:0] mem [DEPTH];  // Word storage
	logic [AW:0]      wr_ptr;       // Write pointer with wrap bit
	logic [AW:0]      rd_ptr;       // Read pointer with wrap bit
	logic             do_wr;        // Accepted write
	logic             do_rd;        // Accepted read

	assign o_in_ready  = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
	assign o_out_valid = wr_ptr != rd_ptr;
	assign o_out_data  = mem[rd_ptr[AW-1:0]];
	assign do_wr       = i_in_valid && o_in_ready;
	assign do_rd       = o_out_valid && i_out_ready;

	// Write side
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ptr <= '0;
		end else if (do_wr) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	// Storage write, no reset needed
	always_ff @(posedge i_clk) begin
		if (do_wr) begin
			mem[wr_ptr[AW-1:0]] <= i_in_data;
		end
	end

	// Read side
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rd_ptr <= '0;
		end else if (do_rd) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// ==== dtu_port.sv ====
`timescale 1ns/10ps
module dtu_port #(
	parameter int unsigned FIFO_DEPTH = dtu_pkg::FIFO_DEPTH
) (
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	input  wire dtu_pkg::dtu_cfg_s i_cfg,
	input  wire logic              i_hibernate,
	input  wire dtu_pkg::dtu_byte_s i_diag_byte,
	output logic                   o_diag_ready,
	input  wire logic              i_boot_log_last,
	output dtu_pkg::dtu_byte_s     o_diag_rx_byte,
	input  wire dtu_pkg::dtu_byte_s i_mlog_byte,
	output logic                   o_mlog_ready,
	output dtu_pkg::dtu_byte_s     o_mlog_rx_byte,
	output logic                   o_diag_line_to_host,
	output logic                   o_diag_line_to_host_oe,
	input  wire logic              i_diag_line_from_host,
	output logic                   o_diag_clear_to_send_out_n,
	output logic                   o_diag_cts_oe,
	input  wire logic              i_diag_request_to_send_in_n,
	output logic                   o_modem_log_host_rx_pin,
	output logic                   o_modem_log_cts_pin_n,
	input  wire logic              i_modem_log_host_tx_pin,
	input  wire logic              i_modem_log_rts_pin_n,
	output logic                   o_boot_done,
	output logic                   o_diag_enabled
);
	initial begin
		if (FIFO_DEPTH < 2) $error("FIFO depth too small");
	end
	localparam logic [15:0] BOOT_DIV = 16'(dtu_pkg::BOOT_DIV);
	localparam logic [15:0] LOG_DIV  = 16'(dtu_pkg::LOG_DIV);

	// ==========================================
	// Phase machine
	// ==========================================
	typedef enum {DTU_PH_BOOT, DTU_PH_DRAIN, DTU_PH_RUN, DTU_PH_OFF} dtu_phase_e;
	dtu_phase_e phase;       // Current phase
	logic       diag_en;     // Diagnostic port active
	logic       diag_fc;     // Diagnostic flow control active
	logic [15:0] diag_div;   // Active diagnostic bit time
	logic       last_take;   // Last boot byte accepted this cycle
	logic       diag_busy;   // Diagnostic transmitter busy
	logic       diag_fifo_v; // Diagnostic FIFO holds data

	// Last boot byte is taken only on an edge where ready stands high
	assign last_take = i_diag_byte.valid && o_diag_ready && i_boot_log_last;

	// Flow control that the configured mode asks for after the boot log
	function automatic logic fc_for(input dtu_pkg::dtu_cfg_s c);
		case (c.mode)
			dtu_pkg::DTU_MODE_LOG, dtu_pkg::DTU_MODE_ALT_LOG: fc_for = !c.log_fc_off;
			dtu_pkg::DTU_MODE_BOOT: fc_for = (c.boot_cfg == dtu_pkg::BOOT_FC_ON);
			default: fc_for = 1'b0;
		endcase
	endfunction

	// Phase progression: boot log, drain, then configured mode
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			phase    <= DTU_PH_BOOT;
			diag_en  <= 1'b1;
			diag_fc  <= 1'b0;
			diag_div <= BOOT_DIV;
		end else begin
			case (phase)
				DTU_PH_BOOT: begin
					// Wait for the last boot byte to be queued
					if (last_take) begin
						phase    <= DTU_PH_DRAIN;
					end
				end
				DTU_PH_DRAIN: begin
					// Apply mode only once the boot log is on the wire
					if (!diag_fifo_v && !diag_busy) begin
						if (i_cfg.mode == dtu_pkg::DTU_MODE_CUSTOMER) begin
							phase   <= DTU_PH_OFF;
							diag_en <= 1'b0;
						end else begin
							phase   <= DTU_PH_RUN;
							diag_fc <= fc_for(i_cfg);
							diag_div <= (i_cfg.mode != dtu_pkg::DTU_MODE_BOOT
								&& !i_cfg.log_baud_sel) ? LOG_DIV : BOOT_DIV;
						end
					end
				end
				DTU_PH_RUN, DTU_PH_OFF: begin
					// Settled until next reset
				end
				default: phase <= DTU_PH_BOOT;
			endcase
		end
	end

	// ==========================================
	// Transmit and receive engines, one per port
	// ==========================================
	logic [1:0] fifo_in_rdy;   // FIFO accept per port
	logic [1:0] fifo_out_v;    // FIFO data present per port
	logic [7:0] fifo_out_d [2];// FIFO head per port
	logic [1:0] tx_take;       // Transmitter pulls a byte
	logic [1:0] port_on;       // Port active
	logic [1:0] cts_ok;        // Host permits sending
	logic [1:0] tx_line;       // Serial output level
	logic [1:0] tx_busy;       // Transmitter in frame
	logic [1:0] rx_v;          // Received byte strobe
	logic [7:0] rx_d [2];      // Received byte
	logic [1:0] rx_pin;        // Serial input level
	logic [15:0] port_div [2]; // Bit time per port
	logic [1:0] in_take;       // Byte accepted per port
	logic [1:0] room_next;     // FIFO has room after this edge
	localparam int unsigned FILL_W = $clog2(FIFO_DEPTH) + 1; // Fill counter width

	// Accept only while the registered ready stands
	assign in_take[0] = i_diag_byte.valid && o_diag_ready;
	assign in_take[1] = i_mlog_byte.valid && o_mlog_ready;

	assign port_on[0] = diag_en && !i_hibernate;
	assign port_on[1] = !i_hibernate;
	assign cts_ok[0]  = !diag_fc || !i_diag_request_to_send_in_n;
	assign cts_ok[1]  = !i_modem_log_rts_pin_n;
	assign rx_pin[0]  = i_diag_line_from_host;
	assign rx_pin[1]  = i_modem_log_host_tx_pin;
	assign port_div[0] = diag_div;
	assign port_div[1] = LOG_DIV;
	assign diag_busy   = tx_busy[0];
	assign diag_fifo_v = fifo_out_v[0];

	for (genvar p = 0; p < 2; p++) begin : g_port
		logic [15:0] tx_cnt;   // Transmit bit timer
		logic [3:0]  tx_bit;   // Transmit bit index
		logic [9:0]  tx_sh;    // Transmit frame shifter
		logic [15:0] rx_cnt;   // Receive bit timer
		logic [3:0]  rx_bit;   // Receive bit index
		logic [7:0]  rx_sh;    // Receive data shifter
		logic        rx_act;   // Receive frame in progress
		logic        rx_prev;  // Previous input level
		logic [FILL_W-1:0] fill; // Words held, tracked beside the FIFO

		// Fill count lets ready be a flop without overrunning the FIFO
		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				fill <= '0;
			end else begin
				fill <= fill + FILL_W'(in_take[p]) - FILL_W'(tx_take[p] && fifo_out_v[p]);
			end
		end

		// Room after this edge decides the next ready
		assign room_next[p] = (fill + FILL_W'(in_take[p])
			- FILL_W'(tx_take[p] && fifo_out_v[p])) < FILL_W'(FIFO_DEPTH);

		dtu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
			.i_clk       (i_clk),
			.i_arst_n    (i_arst_n),
			.i_in_valid  (in_take[p]),
			.o_in_ready  (fifo_in_rdy[p]),
			.i_in_data   (p == 0 ? i_diag_byte.data : i_mlog_byte.data),
			.o_out_valid (fifo_out_v[p]),
			.i_out_ready (tx_take[p]),
			.o_out_data  (fifo_out_d[p])
		);

		assign tx_take[p] = port_on[p] && !tx_busy[p] && cts_ok[p];

		// Transmit one 8N1 frame, LSB first
		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				tx_busy[p] <= 1'b0;
				tx_line[p] <= 1'b1;
				tx_cnt     <= '0;
				tx_bit     <= '0;
				tx_sh      <= '1;
			end else if (!tx_busy[p]) begin
				tx_line[p] <= 1'b1;
				if (tx_take[p] && fifo_out_v[p]) begin
					tx_sh      <= {1'b1, fifo_out_d[p], 1'b0};
					tx_line[p] <= 1'b0; // Start bit lasts a full bit time
					tx_busy[p] <= 1'b1;
					tx_cnt     <= '0;
					tx_bit     <= '0;
				end
			end else if (tx_cnt == 16'(port_div[p] - 16'h1)) begin
				tx_cnt <= '0;
				tx_sh  <= {1'b1, tx_sh[9:1]};
				tx_line[p] <= tx_sh[1];
				if (tx_bit == 4'(dtu_pkg::FRAME_BITS - 1)) begin
					tx_busy[p] <= 1'b0;
				end
				tx_bit <= tx_bit + 4'h1;
			end else begin
				tx_line[p] <= tx_sh[0];
				tx_cnt     <= tx_cnt + 16'h1;
			end
		end

		// Receive: sample mid bit after start edge
		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				rx_act  <= 1'b0;
				rx_prev <= 1'b1;
				rx_cnt  <= '0;
				rx_bit  <= '0;
				rx_sh   <= '0;
				rx_v[p] <= 1'b0;
				rx_d[p] <= '0;
			end else begin
				rx_prev <= rx_pin[p];
				rx_v[p] <= 1'b0;
				if (!port_on[p]) begin
					rx_act <= 1'b0;
				end else if (!rx_act) begin
					if (rx_prev && !rx_pin[p]) begin
						rx_act <= 1'b1;
						rx_cnt <= {1'b0, port_div[p][15:1]};
						rx_bit <= '0;
					end
				end else if (rx_cnt == 16'h0) begin
					rx_cnt <= 16'(port_div[p] - 16'h1);
					rx_bit <= rx_bit + 4'h1;
					if (rx_bit == 4'h0 && rx_pin[p]) begin
						rx_act <= 1'b0; // False start
					end else if (rx_bit == 4'(dtu_pkg::DATA_BITS + 1)) begin
						rx_act <= 1'b0;
						rx_v[p] <= rx_pin[p];
						rx_d[p] <= rx_sh;
					end else if (rx_bit != 4'h0) begin
						rx_sh <= {rx_pin[p], rx_sh[7:1]};
					end
				end else begin
					rx_cnt <= rx_cnt - 16'h1;
				end
			end
		end
	end

	// ==========================================
	// Registered outputs
	// ==========================================
	// Pin drive, all from flops
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_diag_line_to_host        <= 1'b1;
			o_diag_line_to_host_oe     <= 1'b0;
			o_diag_clear_to_send_out_n <= 1'b1;
			o_diag_cts_oe              <= 1'b0;
			o_modem_log_host_rx_pin    <= 1'b1;
			o_modem_log_cts_pin_n      <= 1'b1;
		end else begin
			o_diag_line_to_host        <= tx_line[0];
			o_diag_line_to_host_oe     <= port_on[0];
			o_diag_clear_to_send_out_n <= !(port_on[0] && diag_fc);
			o_diag_cts_oe              <= port_on[0] && diag_fc;
			o_modem_log_host_rx_pin    <= tx_line[1];
			o_modem_log_cts_pin_n      <= !port_on[1];
		end
	end

	// Status and receive strobes
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_diag_ready   <= 1'b0;
			o_mlog_ready   <= 1'b0;
			o_diag_rx_byte <= '0;
			o_mlog_rx_byte <= '0;
			o_boot_done    <= 1'b0;
			o_diag_enabled <= 1'b0;
		end else begin
			// Drop ready on the edge that takes the last boot byte
			o_diag_ready   <= room_next[0] && ((phase == DTU_PH_BOOT && !last_take)
				|| (phase == DTU_PH_RUN));
			o_mlog_ready   <= room_next[1];
			o_diag_rx_byte <= '{valid: rx_v[0], data: rx_d[0]};
			o_mlog_rx_byte <= '{valid: rx_v[1], data: rx_d[1]};
			o_boot_done    <= (phase == DTU_PH_RUN) || (phase == DTU_PH_OFF);
			o_diag_enabled <= diag_en;
		end
	end

	// ==========================================
	// Checks
	// ==========================================
	property p_off_quiet;
		@(posedge i_clk) disable iff (!i_arst_n)
		(phase == DTU_PH_OFF) |=> !o_diag_line_to_host_oe && !o_diag_cts_oe;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("Customer mode port still driven");

	property p_boot_rate;
		@(posedge i_clk) disable iff (!i_arst_n)
		(phase == DTU_PH_BOOT) |-> diag_div == BOOT_DIV;
	endproperty
	a_boot_rate: assert property (p_boot_rate) else $error("Boot log not at boot rate");

	property p_cts_fc;
		@(posedge i_clk) disable iff (!i_arst_n)
		!diag_fc |=> o_diag_clear_to_send_out_n && !o_diag_cts_oe;
	endproperty
	a_cts_fc: assert property (p_cts_fc) else $error("Clear-to-send without flow control");

	property p_hib;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_hibernate |=> !o_diag_line_to_host_oe && o_modem_log_cts_pin_n;
	endproperty
	a_hib: assert property (p_hib) else $error("Port active in hibernate");

	property p_mode_after;
		@(posedge i_clk) disable iff (!i_arst_n)
		(phase == DTU_PH_DRAIN) && (diag_fifo_v || diag_busy) |=> phase == DTU_PH_DRAIN;
	endproperty
	a_mode_after: assert property (p_mode_after) else $error("Mode applied before log drained");

	property p_start_bit;
		@(posedge i_clk) disable iff (!i_arst_n)
		tx_take[0] && fifo_out_v[0] && !tx_busy[0] |=> ##1 !tx_line[0];
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("Missing start bit");

	property p_log_rate;
		@(posedge i_clk) disable iff (!i_arst_n)
		(phase == DTU_PH_DRAIN) && !diag_fifo_v && !diag_busy
			&& (i_cfg.mode == dtu_pkg::DTU_MODE_LOG) && !i_cfg.log_baud_sel
			|=> diag_div == LOG_DIV;
	endproperty
	a_log_rate: assert property (p_log_rate) else $error("Logging rate not applied");

	property p_rts_hold;
		@(posedge i_clk) disable iff (!i_arst_n)
		diag_fc && i_diag_request_to_send_in_n |-> !tx_take[0];
	endproperty
	a_rts_hold: assert property (p_rts_hold) else $error("Sent without request-to-send");

	property p_take_room;
		@(posedge i_clk) disable iff (!i_arst_n)
		(in_take != 2'h0) |-> (fifo_in_rdy & in_take) == in_take;
	endproperty
	a_take_room: assert property (p_take_room) else $error("Byte accepted into full FIFO");

	property p_drain_refuse;
		@(posedge i_clk) disable iff (!i_arst_n)
		(phase == DTU_PH_DRAIN) |-> !o_diag_ready;
	endproperty
	a_drain_refuse: assert property (p_drain_refuse) else $error("Byte accepted while draining");
endmodule

// ==== dtu_host_model.sv ====
`timescale 1ns/10ps
module dtu_host_model (
	input  wire logic        i_clk,
	input  wire logic        i_line,
	input  wire logic        i_cts_n,
	input  wire logic [15:0] i_div,
	output logic             o_line,
	output logic             o_rts_n,
	output logic [7:0]       o_rx_data,
	output int               o_rx_cnt
);
	// ==========================================
	// Host side idle state
	// ==========================================
	initial begin
		o_line    = 1'b1;
		o_rts_n   = 1'b1;
		o_rx_data = 8'h00;
		o_rx_cnt  = 0;
	end

	// ==========================================
	// Receiver, never throttles the device
	// ==========================================
	always begin
		@(negedge i_line);
		repeat (i_div / 2) @(negedge i_clk);
		// Start bit still low at its middle
		if (i_line === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (i_div) @(negedge i_clk);
				o_rx_data[i] = i_line;
			end
			repeat (i_div) @(negedge i_clk);
			// Count only frames with a good stop bit
			if (i_line === 1'b1) begin
				o_rx_cnt++;
			end
		end
	end

	// ==========================================
	// Transmitter: start, data LSB first, stop
	// ==========================================
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge i_clk);
			o_line = f[i];
			repeat (i_div - 1) @(negedge i_clk);
		end
	endtask

	// Request-to-send, raised before log data is expected
	task automatic set_rts(input logic v);
		o_rts_n = v;
	endtask
endmodule

// ==== dtu_port_bench.sv ====
`timescale 1ns/10ps
module dtu_port_bench;
	localparam int unsigned FIFO_D = 4; // Short FIFO keeps fill fast
	logic               i_clk = 1'b0;
	logic               arst_n = 1'b0;
	logic               hib = 1'b0;
	logic               boot_last = 1'b0;
	dtu_pkg::dtu_cfg_s  cfg = 6'h10;
	dtu_pkg::dtu_byte_s diag_byte = 9'h000;
	dtu_pkg::dtu_byte_s mlog_byte = 9'h000;
	dtu_pkg::dtu_byte_s diag_rx, mlog_rx;
	logic [15:0]        ddiv = 16'(dtu_pkg::BOOT_DIV);
	logic               dl, dl_oe, dh_tx, dh_rts_n, cts_n, cts_oe;
	logic               ml, mh_tx, mh_rts_n, mcts_n, dready, mready, done, en;
	logic [7:0]         dh_data, mh_data, drx, mrx, n;
	int                 dh_cnt, mh_cnt, drx_cnt = 0, mrx_cnt = 0;
	int                 error_cnt = 0, compares = 0, cyc = 0;
	dtu_pkg::dtu_cfg_s  tc [4];
	logic [3:0]         te [4];

	// ==========================================
	// Clock, timeout, device receive capture
	// ==========================================
	always #4 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 90000) begin
			error_cnt++;
			summarize();
		end
	end
	// Receive strobes stand one cycle, so look between edges
	always @(negedge i_clk) begin
		if (diag_rx.valid === 1'b1) begin
			drx = diag_rx.data;
			drx_cnt++;
		end
		if (mlog_rx.valid === 1'b1) begin
			mrx = mlog_rx.data;
			mrx_cnt++;
		end
	end

	// ==========================================
	// Device and both host ends
	// ==========================================
	dtu_port #(.FIFO_DEPTH(FIFO_D)) u_dut (
		.i_clk(i_clk), .i_arst_n(arst_n), .i_cfg(cfg), .i_hibernate(hib),
		.i_diag_byte(diag_byte), .o_diag_ready(dready), .i_boot_log_last(boot_last),
		.o_diag_rx_byte(diag_rx), .i_mlog_byte(mlog_byte), .o_mlog_ready(mready),
		.o_mlog_rx_byte(mlog_rx), .o_diag_line_to_host(dl), .o_diag_line_to_host_oe(dl_oe),
		.i_diag_line_from_host(dh_tx), .o_diag_clear_to_send_out_n(cts_n),
		.o_diag_cts_oe(cts_oe), .i_diag_request_to_send_in_n(dh_rts_n),
		.o_modem_log_host_rx_pin(ml), .o_modem_log_cts_pin_n(mcts_n),
		.i_modem_log_host_tx_pin(mh_tx), .i_modem_log_rts_pin_n(mh_rts_n),
		.o_boot_done(done), .o_diag_enabled(en));
	// Host side pull-up when the device releases the line
	dtu_host_model u_dh (.i_clk(i_clk), .i_line(dl_oe ? dl : 1'b1), .i_cts_n(cts_n),
		.i_div(ddiv), .o_line(dh_tx), .o_rts_n(dh_rts_n), .o_rx_data(dh_data),
		.o_rx_cnt(dh_cnt));
	dtu_host_model u_mh (.i_clk(i_clk), .i_line(ml), .i_cts_n(mcts_n),
		.i_div(16'(dtu_pkg::LOG_DIV)), .o_line(mh_tx), .o_rts_n(mh_rts_n),
		.o_rx_data(mh_data), .o_rx_cnt(mh_cnt));

	// ==========================================
	// Compare, access and closing tasks
	// ==========================================
	task automatic chk8(input string s, input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", s, exp, got);
		end
	endtask
	task automatic chk1(input string s, input logic got, input logic exp);
		chk8(s, {7'h00, got}, {7'h00, exp});
	endtask
	// Offer one byte, hold until taken
	task automatic put(input logic sel, input logic [7:0] b, input logic last);
		if (sel) mlog_byte = {1'b1, b};
		else diag_byte = {1'b1, b};
		boot_last = last;
		// Ready is a flop: its level now is what the next edge uses
		while ((sel ? mready : dready) !== 1'b1) @(negedge i_clk);
		@(negedge i_clk);
		mlog_byte.valid = 1'b0;
		diag_byte.valid = 1'b0;
		boot_last = 1'b0;
	endtask
	// Wait for the host to frame one byte
	task automatic get_host(input logic sel, input logic [7:0] exp);
		int c0;
		c0 = sel ? mh_cnt : dh_cnt;
		wait ((sel ? mh_cnt : dh_cnt) != c0);
		chk8("host byte", sel ? mh_data : dh_data, exp);
	endtask
	// Host sends one byte, device must report it once
	task automatic host_to_dev(input logic sel, input logic [7:0] b);
		int c0;
		c0 = sel ? mrx_cnt : drx_cnt;
		if (sel) u_mh.send(b);
		else u_dh.send(b);
		repeat (300) @(negedge i_clk);
		chk8("device byte", sel ? mrx : drx, b);
		chk8("device count", 8'((sel ? mrx_cnt : drx_cnt) - c0), 8'h01);
	endtask
	// Reset with a mode, then the boot log byte
	task automatic boot_with(input dtu_pkg::dtu_cfg_s c);
		@(negedge i_clk);
		arst_n = 1'b0;
		cfg = c;
		ddiv = 16'(dtu_pkg::BOOT_DIV);
		repeat (12) @(negedge i_clk);
		arst_n = 1'b1;
		repeat (2) @(negedge i_clk);
		put(1'b0, 8'ha5, 1'b1);
		get_host(1'b0, 8'ha5);
		wait (done === 1'b1);
		@(negedge i_clk);
		ddiv = 16'(dtu_pkg::LOG_DIV);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================
	// Test sequence
	// ==========================================
	initial begin
		// Mode table: customer, boot, boot with flow, alt log two-wire
		tc[0] = 6'h00;
		tc[1] = 6'h30;
		tc[2] = 6'h31;
		tc[3] = 6'h28;
		// Expected {enabled, line oe, cts oe, cts asserted}
		te[0] = 4'h0;
		te[1] = 4'hc;
		te[2] = 4'hf;
		te[3] = 4'hc;
		boot_with(6'h10);
		chk1("diag enabled", en, 1'b1);
		chk1("cts oe", cts_oe, 1'b1);
		chk1("cts level", cts_n, 1'b0);
		put(1'b0, 8'h3c, 1'b0);
		repeat (2000) @(negedge i_clk);
		chk8("held frames", 8'(dh_cnt), 8'h01);
		u_dh.set_rts(1'b0);
		get_host(1'b0, 8'h3c);
		host_to_dev(1'b0, 8'h96);
		// Fill the modem log FIFO while the host holds off
		n = 8'h00;
		repeat (8) begin
			@(negedge i_clk);
			if (mready === 1'b1) begin
				mlog_byte = {1'b1, 8'h10 + n};
				n++;
			end else mlog_byte.valid = 1'b0;
		end
		chk8("fifo fill", n, 8'(FIFO_D));
		chk1("mlog cts", mcts_n, 1'b0);
		u_mh.set_rts(1'b0);
		for (int k = 0; k < FIFO_D; k++) begin
			get_host(1'b1, 8'(8'h10 + k));
		end
		host_to_dev(1'b1, 8'h5a);
		// Hibernate releases the diagnostic lines
		hib = 1'b1;
		repeat (3) @(negedge i_clk);
		chk1("hib line oe", dl_oe, 1'b0);
		chk1("hib cts oe", cts_oe, 1'b0);
		chk1("hib mlog cts", mcts_n, 1'b1);
		hib = 1'b0;
		for (int i = 0; i < 4; i++) begin
			boot_with(tc[i]);
			chk8("port state", {4'h0, en, dl_oe, cts_oe, ~cts_n}, {4'h0, te[i]});
			chk1("diag ready", dready, te[i][3]);
		end
		// Two-wire logging streams with request-to-send off
		u_dh.set_rts(1'b1);
		put(1'b0, 8'h69, 1'b0);
		get_host(1'b0, 8'h69);
		summarize();
	end
endmodule
